// file: rtl/ldc_cfg.svh
`ifndef LDC_CFG_SVH
`define LDC_CFG_SVH
`define LDC_WAYS 4
`define LDC_SETS 64
`define LDC_LINE_WORDS 8
`define LDC_ADDR_W 32
`define LDC_OFS_W 5
`define LDC_IDX_W 6
`define LDC_RA_THRESH 2'd3
`define LDC_CORES 4
`define LDC_CORE_ID 2'd0
`endif

// file: rtl/ldc_pkg.sv
package ldc_pkg;
    // encoded state: tag valid + shared bit in tag RAM, dirty in dirty RAM
    typedef enum logic [2:0] {
        LDC_I = 3'b000,
        LDC_S = 3'b001,
        LDC_E = 3'b010,
        LDC_O = 3'b011,
        LDC_M = 3'b100
    } ldc_moesi_t;
    typedef enum logic [1:0] {
        LDC_FSM_IDLE = 2'b00,
        LDC_FSM_FILL = 2'b01,
        LDC_FSM_RSTINV = 2'b10
    } ldc_fsm_t;
    typedef enum logic [1:0] {
        LDC_SRC_NONE = 2'b00,
        LDC_SRC_SNOOP = 2'b01,
        LDC_SRC_MAINT = 2'b10,
        LDC_SRC_LSU = 2'b11
    } ldc_src_t;
endpackage : ldc_pkg

// file: rtl/ldc_arb_if.sv
interface ldc_arb_if;
    logic snoop_req;
    logic maint_req;
    logic lsu_req;
    logic inv_req;
    ldc_pkg::ldc_src_t grant;
    modport ctrl (output snoop_req, maint_req, lsu_req, inv_req,
        input grant);
    modport arb (input snoop_req, maint_req, lsu_req, inv_req,
        output grant);
endinterface : ldc_arb_if

// file: rtl/ldc_ram_arb.sv
module ldc_ram_arb (
    ldc_arb_if.arb bus
);
    // fixed priority: reset invalidate blocks all, snoops next
    always_comb begin
        if (bus.inv_req) begin
            bus.grant = ldc_pkg::LDC_SRC_NONE;
        end else if (bus.snoop_req) begin
            bus.grant = ldc_pkg::LDC_SRC_SNOOP;
        end else if (bus.maint_req) begin
            bus.grant = ldc_pkg::LDC_SRC_MAINT;
        end else if (bus.lsu_req) begin
            bus.grant = ldc_pkg::LDC_SRC_LSU;
        end else begin
            bus.grant = ldc_pkg::LDC_SRC_NONE;
        end
    end
endmodule : ldc_ram_arb

// file: rtl/ldc_top.sv
// Overview of operation
// - write-back only; allocate lines on read and write misses normally
// - four-way set associative, physical index and physical tag
// - three consecutive fills fully overwritten first enter read-allocate
// - in read-allocate mode loads still miss into linefills
// - in read-allocate mode store misses go to L2 without a linefill
// - a partial-line cacheable write burst leaves read-allocate mode
// - a load to the line being written out leaves read-allocate mode
// - exclusive monitor set only by local load-exclusive
// - monitor cleared by store-exclusive, remote store, or line eviction
// - each line holds one of modified, owned, exclusive, shared, invalid
// - coherency state kept in tag RAM and dirty RAM
// - coherency request port serves snoop control unit requests
// - maintenance acts on data cache, forwards to instruction cache unit
// - controller drives RAM controls and arbitrates all sources
// - reset in asymmetric mode; shared memory then non-cacheable
// - four-bit output shows each core's coherent mode
// - invalidate whole cache at reset unless inhibit input held
// - in parallel request instruction cache and TLB invalidate-all
`include "ldc_cfg.svh"
module ldc_top #(
    parameter int WAYS = `LDC_WAYS,
    parameter int SETS = `LDC_SETS,
    parameter int TAG_W = `LDC_ADDR_W - `LDC_IDX_W - `LDC_OFS_W
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic reset_invalidate_inhibit_in,
    input wire logic coherent_mode_en_in,
    input wire logic [3:0] other_core_mode_in,
    input wire logic lsu_valid_in,
    input wire logic lsu_store_in,
    input wire logic lsu_excl_in,
    input wire logic lsu_shared_in,
    input wire logic lsu_cacheable_in,
    input wire logic [`LDC_ADDR_W-1:0] lsu_addr_in,
    output logic lsu_ready_out,
    output logic lsu_hit_out,
    output logic excl_ok_out,
    input wire logic fill_done_in,
    input wire logic fill_full_written_in,
    output logic fill_req_out,
    output logic [`LDC_ADDR_W-1:0] fill_addr_out,
    output logic wr_out_req_out,
    output logic [`LDC_ADDR_W-1:0] wr_out_addr_out,
    input wire logic wburst_valid_in,
    input wire logic wburst_cacheable_in,
    input wire logic wburst_full_line_in,
    input wire logic [`LDC_ADDR_W-1:0] wburst_addr_in,
    input wire logic snoop_valid_in,
    input wire logic snoop_inv_in,
    input wire logic snoop_remote_store_in,
    input wire logic [`LDC_ADDR_W-1:0] snoop_addr_in,
    output logic snoop_ready_out,
    output logic snoop_hit_out,
    output logic snoop_dirty_out,
    input wire logic maint_valid_in,
    input wire logic maint_icache_in,
    input wire logic [`LDC_IDX_W-1:0] maint_set_in,
    input wire logic [1:0] maint_way_in,
    output logic maint_ready_out,
    output logic icache_maint_req_out,
    output logic icache_inv_all_out,
    output logic tlb_inv_all_out,
    output logic read_alloc_mode_out,
    output logic excl_state_out,
    output logic rst_inv_busy_out,
    output logic [3:0] core_coherent_mode_flags_out
);
    localparam int IW = `LDC_IDX_W;
    localparam int OW = `LDC_OFS_W;

    function automatic logic [IW-1:0] idx_of(input logic [31:0] a);
        idx_of = a[OW+IW-1:OW];
    endfunction : idx_of

    function automatic logic [TAG_W-1:0] tag_of(input logic [31:0] a);
        tag_of = a[31:OW+IW];
    endfunction : tag_of

    function automatic logic [31:0] line_of(input logic [31:0] a);
        line_of = {a[31:OW], {OW{1'b0}}};
    endfunction : line_of

    // tag RAM: tag, valid and shared; dirty RAM: dirty
    logic [TAG_W-1:0] tag_ram [WAYS][SETS];
    logic [WAYS-1:0] valid_ram [SETS];
    logic [WAYS-1:0] shared_ram [SETS];
    logic [WAYS-1:0] dirty_ram [SETS];

    ldc_pkg::ldc_fsm_t fsm_reg;
    logic [IW-1:0] inv_idx_reg;
    logic [1:0] full_cnt_reg;
    logic ra_mode_reg;
    logic excl_reg;
    logic [31:0] excl_line_reg;
    logic coh_reg;
    logic [1:0] victim_reg;
    logic [31:0] fill_line_reg;
    logic [31:0] wr_line_reg;
    logic wr_busy_reg;
    logic rst_seen_reg;
    ldc_arb_if arb_bus ();

    ldc_ram_arb u_arb (
        .bus(arb_bus)
    );

    assign arb_bus.inv_req = (fsm_reg == ldc_pkg::LDC_FSM_RSTINV);
    assign arb_bus.snoop_req = snoop_valid_in;
    assign arb_bus.maint_req = maint_valid_in;
    assign arb_bus.lsu_req = lsu_valid_in &&
        (fsm_reg == ldc_pkg::LDC_FSM_IDLE) && !rst_seen_reg;

    logic g_lsu, g_snp, g_mnt;
    assign g_lsu = (arb_bus.grant == ldc_pkg::LDC_SRC_LSU);
    assign g_snp = (arb_bus.grant == ldc_pkg::LDC_SRC_SNOOP);
    assign g_mnt = (arb_bus.grant == ldc_pkg::LDC_SRC_MAINT);
    assign lsu_ready_out = g_lsu;
    assign snoop_ready_out = g_snp;
    assign maint_ready_out = g_mnt;

    // lookup: physical index and physical tag
    function automatic logic [WAYS-1:0] match(input logic [31:0] a,
        input logic [WAYS-1:0] vld, input logic [TAG_W-1:0] t0,
        input logic [TAG_W-1:0] t1, input logic [TAG_W-1:0] t2,
        input logic [TAG_W-1:0] t3);
        logic [TAG_W-1:0] t;
        t = tag_of(a);
        match = vld & {t3 == t, t2 == t, t1 == t, t0 == t};
    endfunction : match

    logic [IW-1:0] li, si;
    logic [WAYS-1:0] lhit, shit;
    logic [1:0] lway, sway;
    assign li = idx_of(lsu_addr_in);
    assign si = idx_of(snoop_addr_in);
    assign lhit = match(lsu_addr_in, valid_ram[li], tag_ram[0][li],
        tag_ram[1][li], tag_ram[2][li], tag_ram[3][li]);
    assign shit = match(snoop_addr_in, valid_ram[si], tag_ram[0][si],
        tag_ram[1][si], tag_ram[2][si], tag_ram[3][si]);

    function automatic logic [1:0] enc(input logic [3:0] h);
        enc = h[3] ? 2'd3 : h[2] ? 2'd2 : h[1] ? 2'd1 : 2'd0;
    endfunction : enc

    assign lway = enc(lhit);
    assign sway = enc(shit);

    // asymmetric mode: shared normal memory bypasses the cache
    logic lsu_cach;
    assign lsu_cach = lsu_cacheable_in &&
        !(lsu_shared_in && !coh_reg);

    logic lmiss, need_fill, store_through, evict_dirty;
    assign lmiss = g_lsu && lsu_cach && (lhit == 4'b0000);
    assign need_fill = lmiss && (!lsu_store_in || !ra_mode_reg);
    assign store_through = g_lsu && lsu_store_in &&
        (!lsu_cach || (lmiss && ra_mode_reg));
    assign evict_dirty = need_fill && valid_ram[li][victim_reg] &&
        dirty_ram[li][victim_reg];

    logic [31:0] victim_addr;
    assign victim_addr = {tag_ram[victim_reg][li], li, {OW{1'b0}}};

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            coh_reg <= 1'b0;
        end else begin
            coh_reg <= coherent_mode_en_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            core_coherent_mode_flags_out <= 4'h0;
        end else begin
            core_coherent_mode_flags_out <= other_core_mode_in;
            core_coherent_mode_flags_out[`LDC_CORE_ID] <= coherent_mode_en_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            fsm_reg <= ldc_pkg::LDC_FSM_IDLE;
            inv_idx_reg <= '0;
            rst_seen_reg <= 1'b1;
            fill_line_reg <= 32'h0000_0000;
        end else begin
            rst_seen_reg <= 1'b0;
            case (fsm_reg)
                ldc_pkg::LDC_FSM_IDLE: begin
                    // inhibit sampled at the first edge after release
                    if (rst_seen_reg && !reset_invalidate_inhibit_in) begin
                        fsm_reg <= ldc_pkg::LDC_FSM_RSTINV;
                        inv_idx_reg <= '0;
                    end else if (need_fill) begin
                        fsm_reg <= ldc_pkg::LDC_FSM_FILL;
                        fill_line_reg <= line_of(lsu_addr_in);
                    end
                end
                ldc_pkg::LDC_FSM_FILL: begin
                    if (fill_done_in) begin
                        fsm_reg <= ldc_pkg::LDC_FSM_IDLE;
                    end
                end
                ldc_pkg::LDC_FSM_RSTINV: begin
                    inv_idx_reg <= inv_idx_reg + 1'b1;
                    if (inv_idx_reg == IW'(SETS - 1)) begin
                        fsm_reg <= ldc_pkg::LDC_FSM_IDLE;
                    end
                end
                default: begin
                    fsm_reg <= ldc_pkg::LDC_FSM_IDLE;
                end
            endcase
        end
    end

    assign rst_inv_busy_out = (fsm_reg == ldc_pkg::LDC_FSM_RSTINV);
    assign fill_addr_out = fill_line_reg;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            icache_inv_all_out <= 1'b0;
            tlb_inv_all_out <= 1'b0;
        end else begin
            icache_inv_all_out <= rst_seen_reg &&
                !reset_invalidate_inhibit_in;
            tlb_inv_all_out <= rst_seen_reg &&
                !reset_invalidate_inhibit_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            fill_req_out <= 1'b0;
            icache_maint_req_out <= 1'b0;
        end else begin
            fill_req_out <= need_fill && !(rst_seen_reg &&
                !reset_invalidate_inhibit_in);
            icache_maint_req_out <= g_mnt && maint_icache_in;
        end
    end

    // write-out channel: victims and store misses
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_out_req_out <= 1'b0;
            wr_out_addr_out <= 32'h0000_0000;
            wr_line_reg <= 32'h0000_0000;
            wr_busy_reg <= 1'b0;
        end else begin
            wr_out_req_out <= evict_dirty || store_through;
            if (evict_dirty) begin
                wr_out_addr_out <= victim_addr;
                wr_line_reg <= victim_addr;
                wr_busy_reg <= 1'b1;
            end else if (store_through) begin
                wr_out_addr_out <= lsu_addr_in;
                wr_line_reg <= line_of(lsu_addr_in);
                wr_busy_reg <= 1'b1;
            end else if (wburst_valid_in) begin
                wr_busy_reg <= 1'b0;
            end
        end
    end

    logic leave_ra;
    assign leave_ra = (wburst_valid_in && wburst_cacheable_in &&
        !wburst_full_line_in) ||
        (g_lsu && !lsu_store_in && wr_busy_reg &&
        line_of(lsu_addr_in) == wr_line_reg);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            full_cnt_reg <= 2'd0;
            ra_mode_reg <= 1'b0;
        end else begin
            if (fill_done_in && fsm_reg == ldc_pkg::LDC_FSM_FILL) begin
                if (!fill_full_written_in) begin
                    full_cnt_reg <= 2'd0;
                end else if (full_cnt_reg + 2'd1 == `LDC_RA_THRESH) begin
                    full_cnt_reg <= 2'd0;
                    ra_mode_reg <= 1'b1;
                end else begin
                    full_cnt_reg <= full_cnt_reg + 2'd1;
                end
            end
            if (leave_ra) begin
                ra_mode_reg <= 1'b0;
                full_cnt_reg <= 2'd0;
            end
        end
    end

    assign read_alloc_mode_out = ra_mode_reg;

    // exclusive monitor; set wins only for a local load-exclusive
    logic evict_mon, snoop_clr, excl_clr;
    assign evict_mon = (need_fill && valid_ram[li][victim_reg] &&
        victim_addr == excl_line_reg) ||
        (g_snp && snoop_inv_in &&
        line_of(snoop_addr_in) == excl_line_reg) ||
        (g_mnt && valid_ram[maint_set_in][maint_way_in] &&
        {tag_ram[maint_way_in][maint_set_in], maint_set_in,
        {OW{1'b0}}} == excl_line_reg);
    assign snoop_clr = snoop_valid_in && snoop_remote_store_in &&
        line_of(snoop_addr_in) == excl_line_reg;
    assign excl_clr = (g_lsu && lsu_store_in && lsu_excl_in) ||
        snoop_clr || evict_mon;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            excl_reg <= 1'b0;
            excl_line_reg <= 32'h0000_0000;
        end else if (g_lsu && !lsu_store_in && lsu_excl_in) begin
            excl_reg <= 1'b1;
            excl_line_reg <= line_of(lsu_addr_in);
        end else if (excl_clr) begin
            excl_reg <= 1'b0;
        end
    end

    assign excl_state_out = excl_reg;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            lsu_hit_out <= 1'b0;
            excl_ok_out <= 1'b0;
            snoop_hit_out <= 1'b0;
            snoop_dirty_out <= 1'b0;
            victim_reg <= 2'd0;
        end else begin
            victim_reg <= victim_reg + 2'd1;
            lsu_hit_out <= g_lsu && lsu_cach && (lhit != 4'b0000);
            excl_ok_out <= g_lsu && lsu_store_in && lsu_excl_in &&
                excl_reg && line_of(lsu_addr_in) == excl_line_reg;
            snoop_hit_out <= g_snp && (shit != 4'b0000);
            snoop_dirty_out <= g_snp && (shit != 4'b0000) &&
                dirty_ram[si][sway];
        end
    end

    // state RAMs: M=v,!s,d O=v,s,d E=v,!s,!d S=v,s,!d I=!v
    always_ff @(posedge clk_in) begin
        if (fsm_reg == ldc_pkg::LDC_FSM_RSTINV) begin
            valid_ram[inv_idx_reg] <= 4'b0000;
            dirty_ram[inv_idx_reg] <= 4'b0000;
        end else if (g_snp && (shit != 4'b0000)) begin
            if (snoop_inv_in) begin
                valid_ram[si][sway] <= 1'b0;
                dirty_ram[si][sway] <= 1'b0;
            end else begin
                shared_ram[si][sway] <= 1'b1;
            end
        end else if (g_mnt) begin
            valid_ram[maint_set_in][maint_way_in] <= 1'b0;
            dirty_ram[maint_set_in][maint_way_in] <= 1'b0;
        end else if (need_fill) begin
            tag_ram[victim_reg][li] <= tag_of(lsu_addr_in);
            valid_ram[li][victim_reg] <= 1'b1;
            shared_ram[li][victim_reg] <= lsu_shared_in;
            dirty_ram[li][victim_reg] <= lsu_store_in;
        end else if (g_lsu && lsu_cach && lsu_store_in &&
            (lhit != 4'b0000)) begin
            dirty_ram[li][lway] <= 1'b1;
        end
    end
endmodule : ldc_top

// file: tb/ldc_l2_model.sv
module ldc_l2_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic fill_req_out,
    input wire logic wr_out_req_out,
    input wire logic [31:0] wr_out_addr_out,
    input wire logic full_mode,
    input wire logic slow,
    input wire logic wb_full,
    output logic fill_done_in,
    output logic fill_full_written_in,
    output logic wburst_valid_in,
    output logic wburst_cacheable_in,
    output logic wburst_full_line_in,
    output logic [31:0] wburst_addr_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_reg;
    // one fill outstanding; a slow reply stretches the wait after the counter load from 2 to 11 cycles
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) cnt_reg <= 4'h0;
        else if (fill_req_out) cnt_reg <= slow ? 4'hc : 4'h3;
        else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
    end
    assign fill_done_in = (cnt_reg == 4'h1);
    // qualifier means nothing outside the done pulse, so it is inverted
    assign fill_full_written_in = fill_done_in ? full_mode : !full_mode;
    // each write-out leaves as a burst one cycle later
    always_ff @(posedge clk_in) begin
        wburst_valid_in <= rst_n_in && wr_out_req_out;
        wburst_cacheable_in <= rst_n_in && wr_out_req_out;
        wburst_full_line_in <= wr_out_req_out ? wb_full : !wb_full;
        wburst_addr_in <= wr_out_req_out ? wr_out_addr_out : ~wburst_addr_in;
    end
endmodule : ldc_l2_model

// file: tb/ldc_top_properties.sv
module ldc_top_properties (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic lsu_valid_in,
    input wire logic lsu_store_in,
    input wire logic lsu_excl_in,
    input wire logic lsu_shared_in,
    input wire logic lsu_cacheable_in,
    input wire logic lsu_ready_out,
    input wire logic lsu_hit_out,
    input wire logic fill_req_out,
    input wire logic fill_done_in,
    input wire logic fill_full_written_in,
    input wire logic wburst_valid_in,
    input wire logic wburst_cacheable_in,
    input wire logic wburst_full_line_in,
    input wire logic snoop_valid_in,
    input wire logic snoop_ready_out,
    input wire logic maint_valid_in,
    input wire logic excl_state_out,
    input wire logic read_alloc_mode_out,
    input wire logic rst_inv_busy_out,
    input wire logic icache_inv_all_out,
    input wire logic tlb_inv_all_out,
    input wire logic coherent_mode_en_in,
    input wire logic [3:0] other_core_mode_in,
    input wire logic [3:0] core_coherent_mode_flags_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    excl_set_a: assert property ($rose(excl_state_out) |->
        $past(lsu_valid_in && lsu_ready_out && lsu_excl_in && !lsu_store_in))
        else $error("monitor set without load-exclusive");
    excl_clr_a: assert property ($fell(excl_state_out) |->
        $past(lsu_valid_in || snoop_valid_in || fill_done_in || maint_valid_in))
        else $error("monitor cleared without cause");
    ra_enter_a: assert property ($rose(read_alloc_mode_out) |->
        $past(fill_done_in && fill_full_written_in))
        else $error("read-allocate entered without full-line fill");
    ra_exit_a: assert property (read_alloc_mode_out &&
        wburst_valid_in && wburst_cacheable_in && !wburst_full_line_in
        |=> !read_alloc_mode_out) else $error("partial burst kept mode");
    ra_store_a: assert property (read_alloc_mode_out && lsu_valid_in &&
        lsu_ready_out && lsu_store_in |=> !fill_req_out)
        else $error("store started linefill in read-allocate");
    load_alloc_a: assert property (lsu_valid_in && lsu_ready_out &&
        !lsu_store_in && lsu_cacheable_in && !lsu_shared_in
        |=> lsu_hit_out != fill_req_out) else $error("load neither hit nor fill");
    amp_shared_a: assert property (!core_coherent_mode_flags_out[0] &&
        lsu_valid_in && lsu_ready_out && lsu_shared_in |=> !fill_req_out)
        else $error("shared access allocated in asymmetric mode");
    flags_a: assert property ($past(rst_n_in) |->
        core_coherent_mode_flags_out == {$past(other_core_mode_in[3:1]),
        $past(coherent_mode_en_in)}) else $error("mode flags wrong");
    inv_pulse_a: assert property ($rose(rst_inv_busy_out) |->
        icache_inv_all_out && tlb_inv_all_out)
        else $error("invalidate-all requests missing");
    busy_block_a: assert property (rst_inv_busy_out |->
        !lsu_ready_out) else $error("lsu granted during invalidate");
    snoop_prio_a: assert property (snoop_valid_in && !rst_inv_busy_out
        |-> snoop_ready_out && !lsu_ready_out)
        else $error("snoop not granted first");
endmodule : ldc_top_properties
bind ldc_top ldc_top_properties i_props (.*);

// file: tb/ldc_top_tb.sv
module ldc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 0, rst_n_in = 0, reset_invalidate_inhibit_in = 0;
    logic coherent_mode_en_in = 0, lsu_cacheable_in = 1;
    logic [3:0] other_core_mode_in = 0, core_coherent_mode_flags_out;
    logic lsu_valid_in = 0, lsu_store_in = 0, lsu_excl_in = 0;
    logic lsu_shared_in = 0, snoop_valid_in = 0, snoop_inv_in = 0;
    logic snoop_remote_store_in = 0, maint_valid_in = 0, maint_icache_in = 0;
    logic [31:0] lsu_addr_in = 0, snoop_addr_in = 0;
    logic [31:0] fill_addr_out, wr_out_addr_out, wburst_addr_in;
    logic [5:0] maint_set_in = 0;
    logic [1:0] maint_way_in = 0;
    logic lsu_ready_out, lsu_hit_out, excl_ok_out, fill_done_in;
    logic fill_full_written_in, fill_req_out, wr_out_req_out;
    logic wburst_valid_in, wburst_cacheable_in, wburst_full_line_in;
    logic snoop_ready_out, snoop_hit_out, snoop_dirty_out, maint_ready_out;
    logic icache_maint_req_out, icache_inv_all_out, tlb_inv_all_out;
    logic read_alloc_mode_out, excl_state_out, rst_inv_busy_out;
    logic full_mode = 0, slow = 0, wb_full = 1;
    logic h, f, w, eo, sh, sd, im;
    logic [31:0] wa, fa;
    int mismatches = 0, tests_run = 0;
    ldc_top i_dut (.*);
    ldc_l2_model i_l2 (.*);
    always #4 clk_in = ~clk_in;
    task report_and_stop;
        if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task tick;
        @(posedge clk_in);
        #1;
    endtask : tick
    task automatic grant_wait(ref logic rdy);
        int n;
        #1;
        for (n = 0; n < 300 && rdy !== 1'b1; n++) begin
            @(posedge clk_in);
            #2;
        end
        tick();
    endtask : grant_wait
    task lsu(input logic st, ex, shr, input logic [31:0] a);
        int n;
        lsu_store_in = st;
        lsu_excl_in = ex;
        lsu_shared_in = shr;
        lsu_addr_in = a;
        lsu_valid_in = 1;
        grant_wait(lsu_ready_out);
        lsu_valid_in = 0;
        {h, f, w, eo, wa, fa} = {lsu_hit_out, fill_req_out, wr_out_req_out,
            excl_ok_out, wr_out_addr_out, fill_addr_out};
        if (f === 1'b1) begin
            for (n = 0; n < 100 && fill_done_in !== 1'b1; n++) tick();
            tick();
            tick();
        end
        tick();
    endtask : lsu
    task snp(input logic inv, rs, input logic [31:0] a);
        {snoop_inv_in, snoop_remote_store_in, snoop_addr_in} = {inv, rs, a};
        snoop_valid_in = 1;
        grant_wait(snoop_ready_out);
        snoop_valid_in = 0;
        {sh, sd} = {snoop_hit_out, snoop_dirty_out};
        tick();
    endtask : snp
    task mt(input logic ic, input logic [5:0] s, input logic [1:0] wy);
        {maint_icache_in, maint_set_in, maint_way_in} = {ic, s, wy};
        maint_valid_in = 1;
        grant_wait(maint_ready_out);
        maint_valid_in = 0;
        im = icache_maint_req_out;
        tick();
    endtask : mt
    task rst(input logic inh);
        int n;
        logic iv;
        rst_n_in = 0;
        reset_invalidate_inhibit_in = inh;
        repeat (20) @(posedge clk_in);
        #1 rst_n_in = 1;
        tick();
        iv = 0;
        chk("busy", !inh, rst_inv_busy_out);
        for (n = 0; n < 200 && rst_inv_busy_out === 1'b1; n++) begin
            iv |= icache_inv_all_out && tlb_inv_all_out;
            tick();
        end
        repeat (3) begin
            iv |= icache_inv_all_out || tlb_inv_all_out;
            tick();
        end
        chk("inv_cycles", inh ? 0 : 64, n);
        chk("inv_all", !inh, iv);
    endtask : rst
    task t_ways;
        for (int i = 0; i < 8; i++) begin
            lsu(0, 0, 0, 32'h0000_00a0 + (i % 4) * 32'h0000_0800);
            chk("way_hit", i > 3, h);
            if (i < 4) chk("fill_addr", 32'h0000_00a0 + i * 32'h0000_0800, fa);
        end
    endtask : t_ways
    task t_amp;
        repeat (2) lsu(0, 0, 1, 32'h0000_0500);
        chk("amp_fill", 0, f);
        chk("flags0", 4'h0, core_coherent_mode_flags_out);
        coherent_mode_en_in = 1;
        other_core_mode_in = 4'ha;
        tick();
        tick();
        chk("flags", 4'hb, core_coherent_mode_flags_out);
    endtask : t_amp
    task t_ra;
        for (int i = 0; i < 6; i++) begin
            full_mode = (i != 2);
            slow = i[0];
            lsu(1, 0, 0, (8 + i) << 5);
            chk("st_fill", 1, f);
            chk("ra_mode", i == 5, read_alloc_mode_out);
        end
        lsu(1, 0, 0, 32'h0000_0280);
        chk("ra_fill", 0, f);
        chk("ra_wr", 1, w);
        chk("ra_wr_addr", 32'h0000_0280, wa);
        full_mode = 0;
        lsu(0, 0, 0, 32'h0000_0280);
        chk("ra_ld_fill", 1, f);
        chk("ra_ld_exit", 0, read_alloc_mode_out);
        full_mode = 1;
        for (int i = 21; i < 24; i++) lsu(1, 0, 0, i << 5);
        chk("ra_again", 1, read_alloc_mode_out);
        wb_full = 0;
        lsu(1, 0, 0, 32'h0000_0300);
        for (int n = 0; n < 20 && wburst_valid_in !== 1'b1; n++) tick();
        tick();
        tick();
        chk("ra_burst_exit", 0, read_alloc_mode_out);
    endtask : t_ra
    task t_excl;
        chk("excl0", 0, excl_state_out);
        lsu(0, 1, 0, 32'h0000_03c0);
        chk("excl_set", 1, excl_state_out);
        lsu(1, 1, 0, 32'h0000_03c0);
        chk("sx_ok", 1, eo);
        chk("sx_clr", 0, excl_state_out);
        lsu(1, 1, 0, 32'h0000_03c0);
        chk("sx_fail", 0, eo);
        lsu(0, 1, 0, 32'h0000_03c0);
        snp(0, 1, 32'h0000_03e0);
        chk("excl_keep", 1, excl_state_out);
        snp(0, 1, 32'h0000_03c0);
        chk("excl_remote", 0, excl_state_out);
    endtask : t_excl
    task t_snoop;
        snp(0, 0, 32'h0000_0100);
        chk("snp_m", 2'b11, {sh, sd});
        snp(0, 0, 32'h0000_00a0);
        chk("snp_e", 2'b10, {sh, sd});
        snp(0, 0, 32'h0000_0640);
        chk("snp_i", 1'b0, sh);
        snp(1, 0, 32'h0000_00a0);
        lsu(0, 0, 0, 32'h0000_00a0);
        chk("snp_inv", 1, f);
        for (int i = 0; i < 4; i++) mt(0, 6'h09, i);
        lsu(0, 0, 0, 32'h0000_0120);
        chk("maint_inv", 1, f);
        mt(1, 6'h3f, 2'h0);
        chk("icache_req", 1, im);
    endtask : t_snoop
    initial begin
        rst(0);
        t_ways();
        t_amp();
        t_ra();
        t_excl();
        t_snoop();
        rst(1);
        lsu(0, 0, 0, 32'h0000_00a0);
        chk("inhibit_keep", 1, h);
        rst(0);
        lsu(0, 0, 0, 32'h0000_00a0);
        chk("reset_inv", 0, h);
        report_and_stop();
    end
    initial begin
        #400000;
        mismatches++;
        report_and_stop();
    end
endmodule : ldc_top_tb
